//--- rtl/sgd_pkg.sv
/*
 * Shared constants and carriers of the scatter-gather list DMA register block.
 * Assumes a 32-bit register port and a 32-bit host memory read master port.
 */
package sgd_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] MAIN_CUR_ADDR_OFS = 8'h00;
  localparam logic [7:0] MAIN_NXT_ADDR_OFS = 8'h04;
  localparam logic [7:0] MAIN_CUR_CNT_OFS  = 8'h08;
  localparam logic [7:0] MAIN_NXT_CNT_OFS  = 8'h0C;
  localparam logic [7:0] LIST_CUR_ADDR_OFS = 8'h10;
  localparam logic [7:0] LIST_NXT_ADDR_OFS = 8'h14;
  localparam logic [7:0] LIST_CUR_CNT_OFS  = 8'h18;
  localparam logic [7:0] LIST_NXT_CNT_OFS  = 8'h1C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ENTRY_IRQ_BIT     = 16;
  localparam int MAIN_IDLE_BIT     = 23;
  localparam int ABORT_BIT         = 26;
  localparam int PAGE_IRQ_EN_BIT   = 28;
  localparam int GO_BIT            = 29;
  localparam int LIST_DONE_BIT     = 30;
  localparam int READ_DIR_BIT      = 25;

  // ****************************************
  // Sizes, steps and reset values
  // ****************************************
  localparam int          FIFO_WIDTH   = 32;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [15:0] WORD_BYTES   = 16'h0004;
  localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
  localparam logic [31:0] REG_RESET    = 32'h0000_0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } sgd_reg_req_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } sgd_mem_req_t;

endpackage

//--- rtl/sgd_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes one clock; flush drops all stored words.
 */
`timescale 1ns/1ns
module sgd_fifo
  import sgd_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CW'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

//--- rtl/sgd_list_dma.sv
/*
 * Scatter-gather list DMA channel: host-visible registers, list fetch by
 * bus mastering, entry buffering and main transfer register handover.
 * Assumes a registered-read register port, a single-outstanding memory read
 * master, and a data engine that reports words moved and transfer completion.
 */
`timescale 1ns/1ns
module sgd_list_dma
  import sgd_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // Register port
  input  wire logic        REG_SEL_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  output logic      [31:0] REG_RDATA_OUT,
  // Host memory read master
  output logic             MEM_REQ_OUT,
  output logic      [31:0] MEM_ADDR_OUT,
  input  wire logic        MEM_GNT_IN,
  input  wire logic        MEM_RVALID_IN,
  input  wire logic [31:0] MEM_RDATA_IN,
  // Data engine
  output logic             XFER_ACTIVE_OUT,
  output logic      [31:0] XFER_ADDR_OUT,
  output logic             XFER_READ_OUT,
  input  wire logic        XFER_WORD_IN,
  input  wire logic        XFER_DONE_IN,
  output logic             MAIN_DMA_INT_OUT
);

  // ****************************************
  // Declarations
  // ****************************************
  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_REQ  = 3'b010,
    FS_WAIT = 3'b100
  } sgd_fetch_state_t;

  sgd_reg_req_t     req;
  sgd_mem_req_t     mem;
  sgd_fetch_state_t fetch_state_reg;
  sgd_fetch_state_t fetch_state_next;

  logic [31:0] main_cur_addr_reg;
  logic [31:0] main_nxt_addr_reg;
  logic [31:0] main_cur_cnt_reg;
  logic [31:0] main_nxt_cnt_reg;
  logic [31:0] list_cur_addr_reg;
  logic [31:0] list_nxt_addr_reg;
  logic [31:0] list_cur_cnt_reg;
  logic [31:0] list_nxt_cnt_reg;
  logic        go_ready_reg;
  logic        pending_reg;
  logic        main_nxt_valid_reg;
  logic        main_active_reg;
  logic        have_first_reg;
  logic [31:0] first_word_reg;
  logic [31:0] rdata_next;
  logic        irq_reg;

  logic        reg_wr;
  logic        abort;
  logic        list_done;
  logic        list_load;
  logic        start_fetch;
  logic        word_back;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_out_ready;
  logic [31:0] fifo_out_data;
  logic        entry_take;
  logic        main_load;

  assign req = '{sel: REG_SEL_IN, wr: REG_WR_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN};
  assign reg_wr = req.sel && req.wr;
  assign abort  = reg_wr && (req.addr == LIST_NXT_CNT_OFS) && req.wdata[ABORT_BIT];

  // ****************************************
  // List next registers and go handshake
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      list_nxt_addr_reg <= REG_RESET;
      list_nxt_cnt_reg  <= REG_RESET;
    end else if (reg_wr && go_ready_reg) begin
      if (req.addr == LIST_NXT_ADDR_OFS) begin
        list_nxt_addr_reg <= req.wdata;
      end
      if (req.addr == LIST_NXT_CNT_OFS) begin
        list_nxt_cnt_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      go_ready_reg <= 1'b1;
      pending_reg  <= 1'b0;
    end else if (abort) begin
      go_ready_reg <= 1'b1;
      pending_reg  <= 1'b0;
    end else if (list_load) begin
      go_ready_reg <= 1'b1;
      pending_reg  <= 1'b0;
    end else if (reg_wr && go_ready_reg && (req.addr == LIST_NXT_CNT_OFS)
                 && req.wdata[GO_BIT]) begin
      go_ready_reg <= 1'b0;
      pending_reg  <= 1'b1;
    end
  end

  // ****************************************
  // List current registers and fetch pointer
  // ****************************************
  assign list_done = (list_cur_cnt_reg[15:0] == 16'h0000) && (fetch_state_reg == FS_IDLE);
  assign list_load = pending_reg && list_done;
  // Late word after an abort is dropped, so the count cannot wrap
  assign word_back = (fetch_state_reg == FS_WAIT) && MEM_RVALID_IN
                     && (list_cur_cnt_reg[15:0] != 16'h0000);

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      list_cur_addr_reg <= REG_RESET;
      list_cur_cnt_reg  <= REG_RESET;
    end else if (abort) begin
      list_cur_cnt_reg <= {list_cur_cnt_reg[31:16], 16'h0000};
    end else if (list_load) begin
      list_cur_addr_reg <= list_nxt_addr_reg;
      list_cur_cnt_reg  <= list_nxt_cnt_reg;
    end else if (word_back) begin
      list_cur_addr_reg <= list_cur_addr_reg + ADDR_STEP;
      list_cur_cnt_reg  <= {list_cur_cnt_reg[31:16], list_cur_cnt_reg[15:0] - WORD_BYTES};
    end
  end

  // ****************************************
  // Entry fetch by bus mastering
  // ****************************************
  assign start_fetch = (list_cur_cnt_reg[15:0] != 16'h0000) && fifo_in_ready && !pending_reg;

  always_comb begin
    fetch_state_next = fetch_state_reg;
    unique case (fetch_state_reg)
      FS_IDLE: begin
        if (start_fetch || ((list_cur_cnt_reg[15:0] != 16'h0000) && fifo_in_ready)) begin
          fetch_state_next = FS_REQ;
        end
      end
      FS_REQ: begin
        if (MEM_GNT_IN) begin
          fetch_state_next = FS_WAIT;
        end
      end
      FS_WAIT: begin
        if (MEM_RVALID_IN) begin
          fetch_state_next = FS_IDLE;
        end
      end
      default: begin
        fetch_state_next = FS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      fetch_state_reg <= FS_IDLE;
    end else if (abort && (fetch_state_reg != FS_WAIT)) begin
      fetch_state_reg <= FS_IDLE;
    end else begin
      fetch_state_reg <= fetch_state_next;
    end
  end

  assign mem = '{req: (fetch_state_reg == FS_REQ), addr: list_cur_addr_reg};
  assign MEM_REQ_OUT  = mem.req;
  assign MEM_ADDR_OUT = mem.addr;

  // Room was checked before the request, so the returned word always fits
  sgd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_entry_fifo (
    .clk       (CLK_IN),
    .reset_n   (RESET_N_IN),
    .flush     (abort),
    .in_valid  (word_back),
    .in_ready  (fifo_in_ready),
    .in_data   (MEM_RDATA_IN),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ****************************************
  // Entry pairing into main next registers
  // ****************************************
  assign fifo_out_ready = !have_first_reg || !main_nxt_valid_reg;
  assign entry_take     = fifo_out_valid && have_first_reg && !main_nxt_valid_reg;
  assign main_load      = main_nxt_valid_reg && (!main_active_reg || XFER_DONE_IN);

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      have_first_reg <= 1'b0;
      first_word_reg <= REG_RESET;
    end else if (abort) begin
      have_first_reg <= 1'b0;
    end else if (fifo_out_valid && !have_first_reg) begin
      have_first_reg <= 1'b1;
      first_word_reg <= fifo_out_data;
    end else if (entry_take) begin
      have_first_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      main_nxt_addr_reg  <= REG_RESET;
      main_nxt_cnt_reg   <= REG_RESET;
      main_nxt_valid_reg <= 1'b0;
    end else if (abort) begin
      main_nxt_valid_reg <= 1'b0;
    end else if (entry_take) begin
      main_nxt_addr_reg  <= first_word_reg;
      main_nxt_cnt_reg   <= {list_cur_cnt_reg[31:17], fifo_out_data[ENTRY_IRQ_BIT],
                             fifo_out_data[15:0]};
      main_nxt_valid_reg <= 1'b1;
    end else if (main_load) begin
      main_nxt_valid_reg <= 1'b0;
    end
  end

  // ****************************************
  // Main current registers and completion
  // ****************************************
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      main_cur_addr_reg <= REG_RESET;
      main_cur_cnt_reg  <= REG_RESET;
    end else if (main_load) begin
      main_cur_addr_reg <= main_nxt_addr_reg;
      main_cur_cnt_reg  <= main_nxt_cnt_reg;
    end else if (main_active_reg && XFER_WORD_IN && (main_cur_cnt_reg[15:0] != 16'h0000)) begin
      main_cur_cnt_reg <= {main_cur_cnt_reg[31:16], main_cur_cnt_reg[15:0] - 16'h0001};
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      main_active_reg <= 1'b0;
    end else if (abort) begin
      main_active_reg <= 1'b0;
    end else if (main_load) begin
      main_active_reg <= 1'b1;
    end else if (XFER_DONE_IN) begin
      main_active_reg <= 1'b0;
    end
  end

  // Interrupt pulse for a marked page when page-done is enabled
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= main_active_reg && XFER_DONE_IN && main_cur_cnt_reg[ENTRY_IRQ_BIT]
                 && main_cur_cnt_reg[PAGE_IRQ_EN_BIT];
    end
  end

  assign MAIN_DMA_INT_OUT = irq_reg;
  assign XFER_ACTIVE_OUT  = main_active_reg;
  assign XFER_ADDR_OUT    = main_cur_addr_reg;
  assign XFER_READ_OUT    = main_cur_cnt_reg[READ_DIR_BIT];

  // ****************************************
  // Register read; main registers ignore writes
  // ****************************************
  always_comb begin
    rdata_next = REG_RESET;
    unique case (req.addr)
      MAIN_CUR_ADDR_OFS: rdata_next = main_cur_addr_reg;
      MAIN_NXT_ADDR_OFS: rdata_next = main_nxt_addr_reg;
      MAIN_CUR_CNT_OFS:  rdata_next = main_cur_cnt_reg;
      MAIN_NXT_CNT_OFS:  rdata_next = main_nxt_cnt_reg;
      LIST_CUR_ADDR_OFS: rdata_next = list_cur_addr_reg;
      LIST_NXT_ADDR_OFS: rdata_next = list_nxt_addr_reg;
      LIST_CUR_CNT_OFS:  rdata_next = list_cur_cnt_reg;
      LIST_NXT_CNT_OFS: begin
        rdata_next                = list_nxt_cnt_reg;
        rdata_next[GO_BIT]        = go_ready_reg;
        rdata_next[LIST_DONE_BIT] = list_done && !pending_reg;
        rdata_next[ABORT_BIT]     = 1'b0;
        rdata_next[MAIN_IDLE_BIT] = !main_active_reg;
      end
      default: rdata_next = REG_RESET;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= REG_RESET;
    end else if (req.sel && !req.wr) begin
      REG_RDATA_OUT <= rdata_next;
    end
  end

endmodule

//--- tb/sgd_mem_model.sv
/* Host memory model for the list fetch port.
   Assumes one read outstanding; bench preloads mem. */
`timescale 1ns/1ns
module sgd_mem_model #(
  parameter int LAT = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Read port
  input  wire logic        req_in,
  input  wire logic [31:0] addr_in,
  output logic             gnt_out,
  output logic             rvalid_out,
  output logic      [31:0] rdata_out
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] addr_reg;
  logic        busy_reg;
  int          cnt_reg;

  // Grant, slow answer, data line scrambled when idle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gnt_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= 32'hFFFF_FFFF;
      busy_reg <= 1'b0;
      cnt_reg <= 0;
      addr_reg <= 32'h0;
    end else begin
      gnt_out <= 1'b0;
      rvalid_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (busy_reg) begin
        if (cnt_reg == 0) begin
          rvalid_out <= 1'b1;
          rdata_out <= mem[addr_reg];
          busy_reg <= 1'b0;
        end else begin
          cnt_reg <= cnt_reg - 1;
        end
      end else if (req_in && !gnt_out) begin
        gnt_out <= 1'b1;
        addr_reg <= addr_in;
        busy_reg <= 1'b1;
        cnt_reg <= LAT;
      end
    end
  end
endmodule

//--- tb/sgd_list_dma_monitor.sv
/* Port checker of the list DMA block.
   Assumes binding to sgd_list_dma, one clock. */
`timescale 1ns/1ns
module sgd_list_dma_monitor (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // Register port
  input  wire logic        REG_SEL_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  input  wire logic [31:0] REG_RDATA_OUT,
  // Memory master
  input  wire logic        MEM_REQ_OUT,
  input  wire logic [31:0] MEM_ADDR_OUT,
  input  wire logic        MEM_GNT_IN,
  input  wire logic        MEM_RVALID_IN,
  input  wire logic [31:0] MEM_RDATA_IN,
  // Engine
  input  wire logic        XFER_ACTIVE_OUT,
  input  wire logic [31:0] XFER_ADDR_OUT,
  input  wire logic        XFER_READ_OUT,
  input  wire logic        XFER_WORD_IN,
  input  wire logic        XFER_DONE_IN,
  input  wire logic        MAIN_DMA_INT_OUT
);
  logic out_reg;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  // Read outstanding between grant and data
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      out_reg <= 1'b0;
    end else if (MEM_REQ_OUT && MEM_GNT_IN) begin
      out_reg <= 1'b1;
    end else if (MEM_RVALID_IN) begin
      out_reg <= 1'b0;
    end
  end

  sequence s_req_wait; MEM_REQ_OUT && !MEM_GNT_IN; endsequence
  sequence s_grant; MEM_REQ_OUT && MEM_GNT_IN; endsequence

  property p_req_hold; s_req_wait |=> MEM_REQ_OUT && $stable(MEM_ADDR_OUT); endproperty
  property p_gnt_drop; s_grant |=> !MEM_REQ_OUT; endproperty
  property p_rvalid_gap; MEM_RVALID_IN |=> !MEM_REQ_OUT; endproperty
  property p_one_out; out_reg |-> !MEM_REQ_OUT; endproperty
  property p_int_cause; MAIN_DMA_INT_OUT |-> $past(XFER_DONE_IN && XFER_ACTIVE_OUT); endproperty
  property p_addr_cause;
    $changed(XFER_ADDR_OUT) |-> $past(XFER_DONE_IN) || $rose(XFER_ACTIVE_OUT);
  endproperty
  property p_active_drop;
    $fell(XFER_ACTIVE_OUT) |-> $past(XFER_DONE_IN) || $past(REG_SEL_IN && REG_WR_IN)
      || $past(REG_SEL_IN && REG_WR_IN, 2);
  endproperty
  property p_rdata_hold; (!REG_SEL_IN || REG_WR_IN) |=> $stable(REG_RDATA_OUT); endproperty

  a_req_hold: assert property (p_req_hold) else $error("request dropped or moved");
  a_gnt_drop: assert property (p_gnt_drop) else $error("request after grant");
  a_rvalid_gap: assert property (p_rvalid_gap) else $error("no idle after data");
  a_one_out: assert property (p_one_out) else $error("second read outstanding");
  a_int_cause: assert property (p_int_cause) else $error("interrupt without done");
  a_addr_cause: assert property (p_addr_cause) else $error("address moved alone");
  a_active_drop: assert property (p_active_drop) else $error("active fell alone");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind sgd_list_dma sgd_list_dma_monitor i_mon (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .REG_SEL_IN(REG_SEL_IN), .REG_WR_IN(REG_WR_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_GNT_IN(MEM_GNT_IN),
  .MEM_RVALID_IN(MEM_RVALID_IN), .MEM_RDATA_IN(MEM_RDATA_IN),
  .XFER_ACTIVE_OUT(XFER_ACTIVE_OUT), .XFER_ADDR_OUT(XFER_ADDR_OUT),
  .XFER_READ_OUT(XFER_READ_OUT), .XFER_WORD_IN(XFER_WORD_IN), .XFER_DONE_IN(XFER_DONE_IN),
  .MAIN_DMA_INT_OUT(MAIN_DMA_INT_OUT));

//--- tb/scatter_gather_dma_regs_tb.sv
/* Self-checking bench of the list DMA block.
   Assumes the memory model and the bound checker. */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module scatter_gather_dma_regs_tb
  import sgd_pkg::*;
;
  logic         clk, rst_n, gnt, rvalid, word, done, active, xread, irq;
  logic  [31:0] rdata, mdata, xaddr;
  sgd_reg_req_t rq;
  sgd_mem_req_t mreq;
  int           fail_count, total_checks;

  sgd_list_dma i_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .REG_SEL_IN(rq.sel),
    .REG_WR_IN(rq.wr), .REG_ADDR_IN(rq.addr), .REG_WDATA_IN(rq.wdata), .REG_RDATA_OUT(rdata),
    .MEM_REQ_OUT(mreq.req), .MEM_ADDR_OUT(mreq.addr), .MEM_GNT_IN(gnt), .MEM_RVALID_IN(rvalid),
    .MEM_RDATA_IN(mdata), .XFER_ACTIVE_OUT(active), .XFER_ADDR_OUT(xaddr),
    .XFER_READ_OUT(xread), .XFER_WORD_IN(word), .XFER_DONE_IN(done), .MAIN_DMA_INT_OUT(irq));
  sgd_mem_model i_mem (.clk_in(clk), .rst_n_in(rst_n), .req_in(mreq.req),
    .addr_in(mreq.addr), .gnt_out(gnt), .rvalid_out(rvalid), .rdata_out(mdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); #1 rq = '{1'b1, 1'b1, a, d};
    @(posedge clk); #1 rq.sel = 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk); #1 rq = '{1'b1, 1'b0, a, 32'h0};
    @(posedge clk); #1 rq.sel = 1'b0;
    @(posedge clk); #1 `CHK(rdata & m, e)
  endtask
  task automatic pulse_done(input logic e);
    @(posedge clk); #1 done = 1'b1;
    @(posedge clk); #1 done = 1'b0;
    `CHK(irq, e)
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end

  initial begin
    rq = '0; word = 1'b0; done = 1'b0; rst_n = 1'b0;
    fail_count = 0; total_checks = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    i_mem.mem[32'h1000] = 32'hA000_0000; i_mem.mem[32'h1004] = 32'h0001_0003;
    i_mem.mem[32'h1008] = 32'hB000_0000; i_mem.mem[32'h100C] = 32'h0000_0002;
    i_mem.mem[32'h2000] = 32'hC000_0000; i_mem.mem[32'h2004] = 32'h0001_0001;
    reg_rd(LIST_NXT_CNT_OFS, 32'h6480_0000, 32'h6080_0000);
    for (int i = 0; i < 7; i++) begin
      if (i != 5) reg_wr(8'(i * 4), 32'hFFFF_FFFF);
      reg_rd(8'(i * 4), 32'hFFFF_FFFF, REG_RESET);
    end
    reg_wr(LIST_NXT_ADDR_OFS, 32'h0000_1000);
    reg_rd(LIST_NXT_ADDR_OFS, 32'hFFFF_FFFF, 32'h0000_1000);
    reg_wr(LIST_NXT_CNT_OFS, 32'h3200_0010);
    for (int i = 0; i < 200 && active !== 1'b1; i++) @(posedge clk);
    #1;
    `CHK(active, 1'b1)
    `CHK(xaddr, 32'hA000_0000)
    `CHK(xread, 1'b1)
    reg_rd(LIST_NXT_CNT_OFS, 32'h6480_0000, 32'h2000_0000);
    reg_wr(LIST_NXT_ADDR_OFS, 32'h0000_2000);
    reg_wr(LIST_NXT_CNT_OFS, 32'h2000_0008);
    reg_rd(LIST_NXT_CNT_OFS, 32'h2000_0000, 32'h0);
    reg_wr(LIST_NXT_ADDR_OFS, 32'hDEAD_BEEF);
    reg_rd(LIST_NXT_ADDR_OFS, 32'hFFFF_FFFF, 32'h0000_2000);
    repeat (80) @(posedge clk);
    reg_rd(MAIN_NXT_ADDR_OFS, 32'hFFFF_FFFF, 32'hB000_0000);
    reg_rd(MAIN_NXT_CNT_OFS, 32'h1201_FFFF, 32'h1200_0002);
    reg_rd(MAIN_CUR_ADDR_OFS, 32'hFFFF_FFFF, 32'hA000_0000);
    reg_rd(MAIN_CUR_CNT_OFS, 32'h1201_FFFF, 32'h1201_0003);
    reg_rd(LIST_CUR_ADDR_OFS, 32'hFFFF_FFFF, 32'h0000_2008);
    reg_rd(LIST_CUR_CNT_OFS, 32'h3200_FFFF, 32'h2000_0000);
    reg_rd(LIST_NXT_CNT_OFS, 32'h2000_0000, 32'h2000_0000);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk); #1 word = 1'b1;
      @(posedge clk); #1 word = 1'b0;
    end
    reg_rd(MAIN_CUR_CNT_OFS, 32'h0000_FFFF, 32'h0);
    pulse_done(1'b1);
    `CHK(xaddr, 32'hB000_0000)
    reg_rd(MAIN_CUR_CNT_OFS, 32'h1201_FFFF, 32'h1200_0002);
    repeat (20) @(posedge clk);
    reg_rd(MAIN_NXT_ADDR_OFS, 32'hFFFF_FFFF, 32'hC000_0000);
    pulse_done(1'b0);
    `CHK(xaddr, 32'hC000_0000)
    `CHK(xread, 1'b0)
    reg_rd(MAIN_CUR_CNT_OFS, 32'h1201_FFFF, 32'h0001_0001);
    pulse_done(1'b0);
    `CHK(active, 1'b0)
    @(posedge clk); #1 word = 1'b1;
    @(posedge clk); #1 word = 1'b0;
    reg_rd(MAIN_CUR_CNT_OFS, 32'h0000_FFFF, 32'h0000_0001);
    reg_rd(MAIN_CUR_ADDR_OFS, 32'hFFFF_FFFF, 32'hC000_0000);
    reg_rd(LIST_NXT_CNT_OFS, 32'h6480_0000, 32'h6080_0000);
    reg_rd(8'h20, 32'hFFFF_FFFF, 32'h0);
    tally_and_finish;
  end
endmodule
